// *** pcs_irq_model.sv ***
// interrupt request logic facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module pcs_irq_model #(parameter logic [10:0] VEC = 11'h040) (
  // bench trigger and core acknowledge
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  set_i,
  input  wire logic  ack_i,
  // toward the core
  output logic       req_o,
  output logic [10:0] vec_o
);
  assign vec_o = VEC;
  // flag stays recorded until acknowledged, even with a full stack
  always_ff @(posedge clk_i) req_o <= !rst_i && (set_i || req_o && !ack_i);
endmodule : pcs_irq_model
`default_nettype wire

// *** pcs_params.svh ***
// constants for the program counter and return stack sequencer
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
`define PCS_PC_W        11
`define PCS_STACK_DEPTH 6
`define PCS_RESET_PC    11'h000
`define PCS_PHASE_LAST  2'h3
`define PCS_ADR_PCL     4'h0
`define PCS_ADR_STAT    4'h4
`define PCS_ADR_PCH     4'h8
`endif

// *** pcs_pkg.sv ***
// types for the sequencer
package pcs_pkg;
  typedef enum logic [2:0] {
    PCS_OP_SEQ,
    PCS_OP_JUMP,
    PCS_OP_CALL,
    PCS_OP_RET,
    PCS_OP_SKIP,
    PCS_OP_NONE
  } pcs_op_e;
  typedef struct packed {
    pcs_op_e     op;
    logic        skip_taken;
    logic [10:0] target;
  } pcs_dec_s;
endpackage : pcs_pkg

// *** pcs_props_properties.sv ***
// assertions on the sequencer ports
`timescale 1ns/1ns
`default_nettype none
module pcs_props #(parameter int PC_W = 11) (
  // watched ports
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [PC_W-1:0]   fetch_addr_o,
  input wire logic              fetch_o,
  input wire pcs_pkg::pcs_dec_s dec_i,
  input wire logic              exec_o,
  input wire logic              dummy_o,
  input wire logic              irq_ack_o,
  input wire logic              stack_full_o,
  input wire logic              overflow_o,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [PC_W-1:0] jmp_t;
  wire jump_instruction = exec_o && dec_i.op == pcs_pkg::PCS_OP_JUMP;
  wire skp = exec_o && dec_i.op == pcs_pkg::PCS_OP_SKIP && dec_i.skip_taken;
  // target kept so the landing can be compared cycles later
  always_ff @(posedge clk_i) if (jump_instruction) jmp_t <= dec_i.target;
  sequence gap3; !fetch_o [*3]; endsequence
  sequence land; fetch_o && fetch_addr_o == jmp_t; endsequence
  fetch_gap_a: assert property (fetch_o |=> gap3 ##1 fetch_o)
    else $error("fetch spacing wrong");
  pc_hold_a: assert property (
    !fetch_o && !$past(fetch_o) |-> $stable(fetch_addr_o)) else $error("pc moved");
  exec_next_a: assert property (exec_o || dummy_o |=> fetch_o)
    else $error("no fetch after execute");
  skip_dummy_a: assert property (skp |-> ##4 dummy_o)
    else $error("no dummy cycle");
  jump_land_a: assert property (jump_instruction |-> ##[1:8] land)
    else $error("jump target not fetched");
  bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus not acknowledged");
  full_hold_a: assert property (stack_full_o |-> !irq_ack_o)
    else $error("interrupt taken while full");
  ovf_full_a: assert property ($rose(overflow_o) |-> $past(stack_full_o))
    else $error("overflow without full stack");
  reset_state_a: assert property (
    $fell(rst_i) |-> fetch_addr_o == '0 && !stack_full_o) else $error("reset state");
endmodule : pcs_props
bind pcs_sequencer pcs_props #(.PC_W(PC_W)) u_props (.clk_i, .rst_i,
  .fetch_addr_o, .fetch_o, .dec_i, .exec_o, .dummy_o, .irq_ack_o,
  .stack_full_o, .overflow_o, .cyc_i, .stb_i, .ack_o);
`default_nettype wire

// *** pcs_sequencer.sv ***
// program counter, pipeline and return stack of the core
//
// Chosen here: the address map and the Wishbone slave port.
`include "pcs_params.svh"
`timescale 1ns/1ns
`default_nettype none
module pcs_sequencer #(
  parameter int PC_W  = `PCS_PC_W,
  parameter int DEPTH = `PCS_STACK_DEPTH
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // program memory
  output logic [PC_W-1:0]         fetch_addr_o,
  output logic                    fetch_o,
  // decoded current instruction, valid on instruction cycle end
  input  wire pcs_pkg::pcs_dec_s  dec_i,
  output logic                    exec_o,
  output logic                    dummy_o,
  // interrupt logic
  input  wire logic               irq_req_i,
  input  wire logic [PC_W-1:0]    irq_vector_i,
  output logic                    irq_ack_o,
  output logic                    stack_full_o,
  output logic                    overflow_o,
  // wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [3:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic [31:0]             dat_o,
  output logic                    ack_o
);
  logic [1:0]             phase;
  logic [PC_W-1:0]        pc;
  logic                   pipe_valid;
  logic                   second_cycle;
  logic [PC_W-1:0]        pend_target;
  logic                   pend_call;
  logic [PC_W-1:0]        stack [DEPTH];
  logic [2:0]             sp;
  logic                   overflow;
  logic                   pcl_wr_pend;
  logic [7:0]             pcl_wr_val;

  wire cycle_end   = (phase == `PCS_PHASE_LAST);
  wire cycle_start = (phase == 2'h0);
  wire full        = (sp == 3'(DEPTH));
  wire empty       = (sp == 3'h0);
  wire bus_req     = cyc_i & stb_i & ~ack_o;
  wire sel_pcl     = (adr_i == `PCS_ADR_PCL);
  wire sel_stat    = (adr_i == `PCS_ADR_STAT);
  wire sel_pch     = (adr_i == `PCS_ADR_PCH);
  wire pcl_write   = bus_req & we_i & sel_pcl & sel_i[0];
  wire ovf_clear   = bus_req & we_i & sel_stat & sel_i[0] & dat_i[1];
  // current instruction executes only if its word was really fetched
  wire exec        = cycle_end & pipe_valid & ~second_cycle;
  wire op_jump     = exec & (dec_i.op == pcs_pkg::PCS_OP_JUMP);
  wire op_call     = exec & (dec_i.op == pcs_pkg::PCS_OP_CALL);
  wire op_ret      = exec & (dec_i.op == pcs_pkg::PCS_OP_RET) & ~empty;
  wire op_skip     = exec & (dec_i.op == pcs_pkg::PCS_OP_SKIP)
                     & dec_i.skip_taken;
  // no acknowledge while full; a return this cycle frees room next cycle
  wire irq_take    = cycle_end & irq_req_i & ~full & ~second_cycle
                     & ~op_call & ~op_jump & ~op_ret
                     & ~pcl_wr_pend;
  wire do_push     = (second_cycle & cycle_end & pend_call)
                     | irq_take;
  wire [PC_W-1:0] top_val = stack[sp - 3'h1];
  wire [PC_W-1:0] pcl_target = {pc[PC_W-1:8], pcl_wr_val};

  assign fetch_addr_o = pc;
  assign fetch_o      = cycle_start;
  assign exec_o       = exec;
  assign dummy_o      = cycle_end & ~pipe_valid;
  assign irq_ack_o    = irq_take;
  assign stack_full_o = full;
  assign overflow_o   = overflow;

  // four phases per instruction cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // program counter and pipeline control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc           <= `PCS_RESET_PC;
      pipe_valid   <= 1'b0;
      second_cycle <= 1'b0;
      pend_target  <= '0;
      pend_call    <= 1'b0;
      pcl_wr_pend  <= 1'b0;
      pcl_wr_val   <= 8'h00;
    end else begin
      if (pcl_write) begin
        pcl_wr_pend <= 1'b1;
        pcl_wr_val  <= dat_i[7:0];
      end
      if (cycle_start) begin
        // fetch happens this phase; the word enters the pipe
        pc <= pc + PC_W'(1);
      end
      if (cycle_end) begin
        pipe_valid   <= 1'b1;
        second_cycle <= 1'b0;
        if (second_cycle) begin
          pc         <= pend_target;
          pipe_valid <= 1'b0;
          pend_call  <= 1'b0;
        end else if (irq_take) begin
          pc         <= irq_vector_i;
          pipe_valid <= 1'b0;
        end else if (op_jump | op_call) begin
          // first cycle only latches the target
          second_cycle <= 1'b1;
          pend_target  <= dec_i.target;
          pend_call    <= op_call;
          pipe_valid   <= 1'b0;
        end else if (op_ret) begin
          pc         <= top_val;
          pipe_valid <= 1'b0;
        end else if (pcl_wr_pend & ~pcl_write) begin
          pc          <= pcl_target;
          pipe_valid  <= 1'b0;
          pcl_wr_pend <= 1'b0;
        end else if (op_skip) begin
          pipe_valid <= 1'b0;
        end
      end
    end
  end

  // return stack; pc already points past the current word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp       <= 3'h0;
      overflow <= 1'b0;
    end else begin
      if (do_push) begin
        if (full) begin
          // shift out the oldest entry
          for (int i = 0; i < DEPTH - 1; i++) begin
            stack[i] <= stack[i+1];
          end
          stack[DEPTH-1] <= pc;
          overflow       <= 1'b1;
        end else begin
          stack[sp] <= pc;
          sp        <= sp + 3'h1;
        end
      end else if (op_ret) begin
        sp <= sp - 3'h1;
      end
      if (ovf_clear & ~(do_push & full)) begin
        overflow <= 1'b0;
      end
    end
  end

  // wishbone answers one cycle after the strobe
  wire [31:0] rd_data =
    sel_pcl  ? {24'h000000, pc[7:0]} :
    sel_stat ? {30'h0, overflow, full} :
    sel_pch  ? {{(32-PC_W){1'b0}}, pc} : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= bus_req;
      if (bus_req & ~we_i) begin
        dat_o <= rd_data;
      end
    end
  end
endmodule : pcs_sequencer
`default_nettype wire

// *** test_pcs_sequencer.sv ***
// self-checking bench for the sequencer
`timescale 1ns/1ns
`default_nettype none
module test_pcs_sequencer;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, irq_set = 0;
  logic [3:0] adr_i = '0, sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, rd;
  logic [10:0] fetch_addr_o, vec;
  logic fetch_o, exec_o, dummy_o, irq_ack_o, stack_full_o, overflow_o;
  logic ack_o, irq_req;
  pcs_pkg::pcs_dec_s dec_i = '0;
  int n_mismatch = 0, cmp_count = 0, cyc_n = 0;
  pcs_sequencer DUT (.clk_i, .rst_i, .fetch_addr_o, .fetch_o, .dec_i,
    .exec_o, .dummy_o, .irq_req_i(irq_req), .irq_vector_i(vec), .irq_ack_o,
    .stack_full_o, .overflow_o, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o);
  pcs_irq_model #(.VEC(11'h040)) irq (.clk_i, .rst_i, .set_i(irq_set),
    .ack_i(irq_ack_o), .req_o(irq_req), .vec_o(vec));
  initial forever #10 clk_i = ~clk_i;
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge clk_i) if (++cyc_n == 5000) begin
    n_mismatch++;
    give_verdict();
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask : wb
  // holds op until its phase-3 edge, then straight-line code follows
  task automatic run(input pcs_pkg::pcs_op_e op, input logic [10:0] t);
    dec_i <= '{op, 1'b1, t};
    // a dummy cycle does not consume the op, so wait for real execution
    do @(negedge clk_i); while (exec_o !== 1'b1);
    @(posedge clk_i);
    dec_i <= '{pcs_pkg::PCS_OP_SEQ, 1'b0, 11'h000};
  endtask : run
  task automatic land(input logic [10:0] a);
    logic hit = 0;
    for (int i = 0; i < 64 && !hit; i++) begin
      @(negedge clk_i);
      hit = fetch_o === 1'b1 && fetch_addr_o === a;
    end
    @(posedge clk_i);
    chk({31'h0, hit}, 32'h1);
  endtask : land
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 4'h8, 0);
    chk(rd, 0);
    wb(0, 4'h4, 0);
    chk(rd, 0);
    land(11'h004);
    run(pcs_pkg::PCS_OP_JUMP, 11'h150);
    land(11'h150);
    wb(1, 4'h0, 32'h34);
    land(11'h134);
    wb(0, 4'h0, 0);
    chk(rd >> 8, 0);
    wb(1, 4'hC, 32'hFF);
    wb(0, 4'hC, 0);
    chk(rd, 0);
    run(pcs_pkg::PCS_OP_SKIP, 0);
    land(11'h13C);
    for (int i = 0; i < 6; i++) begin
      run(pcs_pkg::PCS_OP_CALL, 11'h200 + 11'(i * 16));
      land(11'h200 + 11'(i * 16));
    end
    wb(0, 4'h4, 0);
    chk(rd, 1);
    irq_set <= 1;
    @(posedge clk_i);
    irq_set <= 0;
    land(11'h25C);
    run(pcs_pkg::PCS_OP_CALL, 11'h300);
    land(11'h300);
    wb(0, 4'h4, 0);
    chk(rd, 3);
    wb(1, 4'h4, 2);
    run(pcs_pkg::PCS_OP_RET, 0);
    land(11'h040);
    wb(0, 4'h4, 0);
    chk(rd, 1);
    give_verdict();
  end
endmodule : test_pcs_sequencer
`default_nettype wire
